//--- hw/tsc_pkg.sv
/*
 * tsc_pkg: constants shared by the timer status/control block.
 * Assumes a single 8-bit register reached over a plain strobe port.
 */
package tsc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int PS_W = 3;
    localparam int PS_CNT_W = 7;
    localparam int CLKS_W = 2;

    localparam logic [ADDR_W-1:0] SC_OFFSET = 8'h00;

    localparam int OVF_FLAG_BIT = 7;
    localparam int OVF_IRQ_EN_BIT = 6;
    localparam int CENTER_PWM_BIT = 5;
    localparam int CLKS_HI_BIT = 4;
    localparam int CLKS_LO_BIT = 3;
    localparam int PS_HI_BIT = 2;
    localparam int PS_LO_BIT = 0;

    localparam logic [DATA_W-1:0] SC_RESET = 8'h00;
    localparam logic [CLKS_W-1:0] CLKS_RESET = 2'h0;
    localparam logic [PS_W-1:0] PS_RESET = 3'h0;
    localparam logic [CNT_W-1:0] CNT_RESET = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_WRAP = 16'h0000;
    localparam logic [CNT_W-1:0] CNT_FREE_TOP = 16'hffff;
    localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;

    typedef enum logic [CLKS_W-1:0] {
        TSC_CLK_OFF = 2'h0,
        TSC_CLK_BUS = 2'h1,
        TSC_CLK_FIXED = 2'h2,
        TSC_CLK_EXT = 2'h3
    } tsc_clk_src_e;
endpackage

//--- hw/tsc_tick_if.sv
/*
 * tsc_tick_if: carries the selected clock tick and prescale factor to the
 * prescaler and the divided tick back. Assumes one clock domain.
 */
`timescale 1ns/1ps
interface tsc_tick_if;
    logic src_tick;
    logic [2:0] ps_sel;
    logic div_tick;

    modport ctrl (output src_tick, output ps_sel, input div_tick);
    modport presc (input src_tick, input ps_sel, output div_tick);
endinterface

//--- hw/tsc_sync.sv
/*
 * tsc_sync: two-flop synchroniser for the external clock pin with a
 * rising-edge pulse. Assumes the pin toggles at most at a quarter of sys_clk.
 */
`timescale 1ns/1ps
module tsc_sync (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic pin_in,
    output logic rise_pulse
);
    logic meta_reg;
    logic sync_reg;
    logic prev_reg;

    // only the second flop reads the first one
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
            prev_reg <= 1'b0;
        end else if (clk_en) begin
            meta_reg <= pin_in;
            sync_reg <= meta_reg;
            prev_reg <= sync_reg;
        end
    end

    assign rise_pulse = sync_reg & ~prev_reg;
endmodule

//--- hw/tsc_prescaler.sv
/*
 * tsc_prescaler: divides the selected tick by two to the power ps_sel.
 * Assumes src_tick is a one-cycle enable on sys_clk.
 */
`timescale 1ns/1ps
module tsc_prescaler
    import tsc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    tsc_tick_if.presc tick
);
    logic [PS_CNT_W-1:0] div_reg;
    logic [PS_CNT_W-1:0] mask;

    // mask comes straight from the register bits, so a new factor acts next cycle
    assign mask = PS_CNT_W'((8'h01 << tick.ps_sel) - 8'h01);

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            div_reg <= '0;
        end else if (clk_en && tick.src_tick) begin
            div_reg <= div_reg + 1'b1;
        end
    end

    assign tick.div_tick = tick.src_tick && ((div_reg & mask) == mask);
endmodule

//--- hw/tsc_top.sv
/*
 * tsc_top: status/control register of a 16-bit timer with its counter,
 * clock source selection, prescaler and overflow flag.
 * Assumes modulo_value and fixed_clk_tick come from sys_clk logic; the
 * external clock pin is asynchronous.
 */
`timescale 1ns/1ps
module tsc_top (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [tsc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tsc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [tsc_pkg::DATA_W-1:0] reg_rdata,
    input wire logic [tsc_pkg::CNT_W-1:0] modulo_value,
    input wire logic ext_clk_pin,
    input wire logic fixed_clk_tick,
    input wire logic pll_active,
    output logic overflow_irq,
    output logic [tsc_pkg::CNT_W-1:0] count_value,
    output logic count_down,
    output logic center_pwm_mode,
    output logic pins_to_gpio,
    output logic coherency_restart
);
    import tsc_pkg::*;

    tsc_tick_if tick ();

    logic overflow_flag_reg;
    logic overflow_flag_next;
    logic clear_armed_reg;
    logic clear_armed_next;
    logic overflow_irq_enable_reg;
    logic center_pwm_select_reg;
    logic [CLKS_W-1:0] clock_source_sel_reg;
    logic [PS_W-1:0] prescale_sel_reg;
    logic [CNT_W-1:0] count_reg;
    logic down_reg;
    logic [DATA_W-1:0] rdata_reg;
    logic irq_reg;
    logic gpio_reg;
    logic restart_reg;
    logic sc_hit;
    logic sc_wr;
    logic sc_rd;
    logic ext_rise;
    logic ovf_evt;
    logic [CNT_W-1:0] top_value;
    logic [DATA_W-1:0] sc_view;

    assign sc_hit = (reg_addr == SC_OFFSET);
    assign sc_wr = clk_en && reg_wr && sc_hit;
    assign sc_rd = clk_en && reg_rd && sc_hit;

    tsc_sync u_ext_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .pin_in(ext_clk_pin),
        .rise_pulse(ext_rise)
    );

    // source selection feeds the prescaler, never the other way round
    always_comb begin
        unique case (tsc_clk_src_e'(clock_source_sel_reg))
            TSC_CLK_OFF: tick.src_tick = 1'b0;
            TSC_CLK_BUS: tick.src_tick = 1'b1;
            TSC_CLK_FIXED: tick.src_tick = pll_active ? fixed_clk_tick : 1'b1;
            TSC_CLK_EXT: tick.src_tick = ext_rise;
        endcase
    end

    assign tick.ps_sel = prescale_sel_reg;

    tsc_prescaler u_presc (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .tick(tick)
    );

    // a zero modulo means free running over the full range
    assign top_value = (modulo_value == CNT_WRAP) ? CNT_FREE_TOP : modulo_value;

    always_comb begin
        ovf_evt = 1'b0;
        if (tick.div_tick) begin
            if (!center_pwm_select_reg) begin
                ovf_evt = (count_reg >= top_value);
            end else begin
                ovf_evt = down_reg && (count_reg == 16'h0001);
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            count_reg <= CNT_RESET;
            down_reg <= 1'b0;
        end else if (clk_en && !tick.div_tick && !center_pwm_select_reg) begin
            // leaving center mode must not leave a stale down indication while ticks are slow
            down_reg <= 1'b0;
        end else if (clk_en && tick.div_tick) begin
            if (!center_pwm_select_reg) begin
                down_reg <= 1'b0;
                if (count_reg >= top_value) begin
                    count_reg <= CNT_WRAP;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end else if (!down_reg) begin
                if (count_reg >= top_value) begin
                    down_reg <= 1'b1;
                    count_reg <= count_reg - 1'b1;
                end else begin
                    count_reg <= count_reg + 1'b1;
                end
            end else if (count_reg == CNT_WRAP) begin
                down_reg <= 1'b0;
                count_reg <= count_reg + 1'b1;
            end else begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

    // the set of a new overflow wins over a clear in the same cycle
    always_comb begin
        overflow_flag_next = overflow_flag_reg;
        clear_armed_next = clear_armed_reg;
        if (sc_rd && overflow_flag_reg) begin
            clear_armed_next = 1'b1;
        end
        if (sc_wr) begin
            clear_armed_next = 1'b0;
            if (clear_armed_reg && !reg_wdata[OVF_FLAG_BIT]) begin
                overflow_flag_next = 1'b0;
            end
        end
        if (ovf_evt) begin
            overflow_flag_next = 1'b1;
            clear_armed_next = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            overflow_flag_reg <= 1'b0;
            clear_armed_reg <= 1'b0;
        end else if (clk_en) begin
            overflow_flag_reg <= overflow_flag_next;
            clear_armed_reg <= clear_armed_next;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            overflow_irq_enable_reg <= SC_RESET[OVF_IRQ_EN_BIT];
            center_pwm_select_reg <= SC_RESET[CENTER_PWM_BIT];
            clock_source_sel_reg <= CLKS_RESET;
            prescale_sel_reg <= PS_RESET;
        end else if (sc_wr) begin
            overflow_irq_enable_reg <= reg_wdata[OVF_IRQ_EN_BIT];
            center_pwm_select_reg <= reg_wdata[CENTER_PWM_BIT];
            clock_source_sel_reg <= reg_wdata[CLKS_HI_BIT:CLKS_LO_BIT];
            prescale_sel_reg <= reg_wdata[PS_HI_BIT:PS_LO_BIT];
        end
    end

    assign sc_view = {overflow_flag_reg, overflow_irq_enable_reg, center_pwm_select_reg,
                      clock_source_sel_reg, prescale_sel_reg};

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= RD_UNMAPPED;
        end else if (clk_en) begin
            if (reg_rd) begin
                rdata_reg <= sc_hit ? sc_view : RD_UNMAPPED;
            end else begin
                rdata_reg <= RD_UNMAPPED;
            end
        end
    end

    // outputs are registered from next values so they track the flag without lag
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_reg <= 1'b0;
            gpio_reg <= 1'b1;
            restart_reg <= 1'b0;
        end else if (clk_en) begin
            irq_reg <= overflow_flag_next && (sc_wr ? reg_wdata[OVF_IRQ_EN_BIT]
                                                    : overflow_irq_enable_reg);
            gpio_reg <= sc_wr ? (reg_wdata[CLKS_HI_BIT:CLKS_LO_BIT] == CLKS_RESET)
                              : (clock_source_sel_reg == CLKS_RESET);
            restart_reg <= sc_wr;
        end
    end

    assign reg_rdata = rdata_reg;
    assign overflow_irq = irq_reg;
    assign count_value = count_reg;
    assign count_down = down_reg;
    assign center_pwm_mode = center_pwm_select_reg;
    assign pins_to_gpio = gpio_reg;
    assign coherency_restart = restart_reg;
endmodule

//--- test/tsc_top_sva.sv
/* tsc_top_sva: port checker for the timer status/control block.
   Assumes one sys_clk domain and resetn asynchronous active low. */
`timescale 1ns/1ps
module tsc_top_sva (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [tsc_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tsc_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic overflow_irq,
    input wire logic [tsc_pkg::CNT_W-1:0] count_value,
    input wire logic count_down,
    input wire logic center_pwm_mode,
    input wire logic pins_to_gpio,
    input wire logic coherency_restart
);
    import tsc_pkg::*;
    logic sc_wr;
    logic cpwm_wr;
    logic [1:0] src_wr;
    assign sc_wr = clk_en && reg_wr && (reg_addr == SC_OFFSET);
    assign cpwm_wr = reg_wdata[CENTER_PWM_BIT];
    assign src_wr = reg_wdata[CLKS_HI_BIT:CLKS_LO_BIT];
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    irq_off_a: assert property (sc_wr && !reg_wdata[OVF_IRQ_EN_BIT] |=> !overflow_irq)
        else $error("irq up with enable clear");
    irq_hold_a: assert property (overflow_irq && !sc_wr |=> overflow_irq)
        else $error("irq fell without a write");
    restart_pulse_a: assert property (sc_wr |=> coherency_restart)
        else $error("no restart after write");
    restart_cause_a: assert property (coherency_restart |-> $past(sc_wr))
        else $error("restart without write");
    center_sel_a: assert property (sc_wr |=> center_pwm_mode == $past(cpwm_wr))
        else $error("center select not taken");
    gpio_rel_a: assert property (sc_wr |=> pins_to_gpio == ($past(src_wr) == 2'h0))
        else $error("pin release wrong");
    up_only_a: assert property (!center_pwm_mode [*2] |-> !count_down)
        else $error("down count in up mode");
    count_frozen_a: assert property ($past(pins_to_gpio) |-> $stable(count_value))
        else $error("counter moved with no clock");
    cover property (coherency_restart);
    cover property (overflow_irq);
    cover property (count_down);
endmodule
bind tsc_top tsc_top_sva u_sva (.*);

//--- test/test_timer_status_control.sv
/* test_timer_status_control: self-checking bench for tsc_top.
   Assumes the register at SC_OFFSET and a bus source of one tick a cycle. */
`timescale 1ns/1ps
module test_timer_status_control;
    import tsc_pkg::*;
    logic sys_clk, resetn, clk_en, reg_wr, reg_rd, ext_clk_pin, fixed_clk_tick, pll_active;
    logic overflow_irq, count_down, center_pwm_mode, pins_to_gpio, coherency_restart;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, cyc, v, d;
    logic [15:0] modulo_value, count_value, m;
    int err_count, compares, n;
    tsc_top DUT (.*);
    initial begin
        sys_clk = 1'b0;
        forever #2 sys_clk = ~sys_clk;
    end
    // ext pin at an eighth of sys_clk, fixed tick every fourth cycle
    always @(posedge sys_clk) begin
        cyc <= cyc + 8'h01;
        ext_clk_pin <= cyc[2];
        fixed_clk_tick <= (cyc[1:0] == 2'h0);
    end
    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t reg %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t val %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr_sc(input logic [7:0] a, input logic [7:0] x);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= x;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask
    task automatic rd_sc(input logic [7:0] a, output logic [7:0] x);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 x = reg_rdata;
    endtask
    // expected counts in a 256-cycle window
    function automatic logic [15:0] rate(input logic [1:0] s, input logic p, input logic [2:0] ps);
        logic [15:0] r;
        r = (s == TSC_CLK_OFF) ? 16'h0000 : (s == TSC_CLK_EXT) ? 16'h0020 :
            (s == TSC_CLK_FIXED && p) ? 16'h0040 : 16'h0100;
        return r >> ps;
    endfunction
    task automatic rate_chk(input logic [1:0] s, input logic p, input logic [2:0] ps);
        logic [15:0] a;
        pll_active <= p;
        wr_sc(SC_OFFSET, {3'h0, s, ps});
        repeat (8) @(posedge sys_clk);
        #1 a = count_value;
        repeat (256) @(posedge sys_clk);
        #1 chk_val(count_value - a, rate(s, p, ps));
        chk_val({15'h0, pins_to_gpio}, {15'h0, s == TSC_CLK_OFF});
    endtask
    task automatic print_verdict();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        #80000;
        err_count++;
        print_verdict();
    end
    initial begin
        {resetn, reg_wr, reg_rd, pll_active, cyc, reg_addr, reg_wdata} = '0;
        clk_en = 1'b1;
        modulo_value = 16'h0000;
        void'($urandom(32'h0000_08d7));
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        rd_sc(SC_OFFSET, d);
        chk_reg(d, SC_RESET);
        chk_val({15'h0, pins_to_gpio}, 16'h0001);
        for (n = 0; n < 6; n++) begin
            v = 8'($urandom);
            wr_sc(SC_OFFSET, v & 8'he7);
            wr_sc(8'h01 + 8'($urandom % 255), ~v);
            rd_sc(8'h01 + 8'($urandom % 255), d);
            chk_reg(d, RD_UNMAPPED);
            rd_sc(SC_OFFSET, d);
            chk_reg(d, v & 8'h67);
            chk_val({15'h0, center_pwm_mode}, {15'h0, v[5]});
        end
        $display("test register finished");
        m = 16'h0008 + 16'($urandom % 32);
        modulo_value <= m;
        wr_sc(SC_OFFSET, 8'h28);
        for (n = 0; n < 200 && count_down !== 1'b1; n++) @(posedge sys_clk);
        chk_val({15'h0, count_down}, 16'h0001);
        $display("test center finished");
        wr_sc(SC_OFFSET, 8'h48);
        for (n = 0; n < 200 && overflow_irq !== 1'b1; n++) @(posedge sys_clk);
        chk_val({15'h0, overflow_irq}, 16'h0001);
        rd_sc(SC_OFFSET, d);
        repeat (m + 3) @(posedge sys_clk);
        wr_sc(SC_OFFSET, 8'h40);
        rd_sc(SC_OFFSET, d);
        chk_reg(d, 8'hc0);
        wr_sc(SC_OFFSET, 8'hc0);
        chk_val({15'h0, overflow_irq}, 16'h0001);
        wr_sc(SC_OFFSET, 8'h40);
        chk_val({15'h0, overflow_irq}, 16'h0001);
        wr_sc(SC_OFFSET, 8'h80);
        chk_val({15'h0, overflow_irq}, 16'h0000);
        rd_sc(SC_OFFSET, d);
        chk_reg(d, 8'h80);
        wr_sc(SC_OFFSET, 8'h40);
        rd_sc(SC_OFFSET, d);
        chk_reg(d, 8'h40);
        $display("test overflow finished");
        modulo_value <= 16'h0000;
        for (n = 0; n < 8; n++) rate_chk(TSC_CLK_BUS, 1'b0, 3'(n));
        rate_chk(TSC_CLK_FIXED, 1'b0, 3'($urandom % 8));
        rate_chk(TSC_CLK_FIXED, 1'b1, 3'($urandom % 7));
        rate_chk(TSC_CLK_EXT, 1'b0, 3'($urandom % 6));
        rate_chk(TSC_CLK_OFF, 1'b0, 3'($urandom % 8));
        $display("test rate finished");
        // clock enable low freezes the counter and refuses register strobes
        wr_sc(SC_OFFSET, 8'h08);
        chk_val({15'h0, coherency_restart}, 16'h0001);
        @(posedge sys_clk);
        clk_en <= 1'b0;
        @(posedge sys_clk);
        #1 m = count_value;
        wr_sc(SC_OFFSET, 8'h00);
        repeat (4) @(posedge sys_clk);
        #1 chk_val(count_value, m);
        chk_val({15'h0, coherency_restart}, 16'h0000);
        @(posedge sys_clk);
        clk_en <= 1'b1;
        rd_sc(SC_OFFSET, d);
        chk_reg(d, 8'h08);
        $display("test enable finished");
        print_verdict();
    end
endmodule
